// File: rtl/smsd_decoder.sv
`default_nettype none

module smsd_decoder (
  input  wire logic               CLK_SYS_IN,
  input  wire logic               RESET_IN,
  input  wire logic               SYS_MGMT_MODE_IN,
  input  wire smsd_pkg::smsd_txn_t TXN_IN,
  output var  smsd_pkg::smsd_route_t ROUTE_OUT,
  input  wire logic [7:0]         REG_ADDR_IN,
  input  wire logic [31:0]        REG_WDATA_IN,
  input  wire logic               REG_WR_IN,
  input  wire logic               REG_RD_IN,
  output logic      [31:0]        REG_RDATA_OUT
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Inclusive range test, shared by the compatible, high and BIOS decodes
  function automatic logic in_range(input logic [35:0] a,
                                    input logic [35:0] lo,
                                    input logic [35:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [3:0]  ctrl;
  logic [1:0]  shadow;
  logic [31:0] ceiling;
  logic [31:0] tsize;
  logic [15:0] blocked_cnt;

  // Register decode
  wire logic wr_ctrl   = REG_WR_IN && (REG_ADDR_IN == smsd_pkg::REG_CTRL);
  wire logic wr_shadow = REG_WR_IN && (REG_ADDR_IN == smsd_pkg::REG_SHADOW);
  wire logic wr_ceil   = REG_WR_IN && (REG_ADDR_IN == smsd_pkg::REG_CEIL);
  wire logic wr_tsize  = REG_WR_IN && (REG_ADDR_IN == smsd_pkg::REG_TSIZE);

  // Software writes; reserved bits are dropped
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      ctrl    <= smsd_pkg::CTRL_RST;
      shadow  <= smsd_pkg::SHADOW_RST;
      ceiling <= smsd_pkg::CEIL_RST;
      tsize   <= smsd_pkg::TSIZE_RST;
    end else begin
      if (wr_ctrl)   ctrl    <= REG_WDATA_IN[3:0];
      if (wr_shadow) shadow  <= REG_WDATA_IN[1:0];
      if (wr_ceil)   ceiling <= REG_WDATA_IN;
      if (wr_tsize)  tsize   <= REG_WDATA_IN;
    end
  end

  // ****************************************************************
  // Window enables
  // ****************************************************************
  // Enable table: high bit chooses between the compatible and high windows
  wire logic global_en  = ctrl[smsd_pkg::CTRL_GLOBAL];
  wire logic compat_act = global_en && !ctrl[smsd_pkg::CTRL_HIGH];
  wire logic high_act   = global_en && ctrl[smsd_pkg::CTRL_HIGH];
  wire logic top_act    = global_en && ctrl[smsd_pkg::CTRL_TOP];
  // Open bit lets firmware reach the RAM outside management mode
  wire logic visible    = SYS_MGMT_MODE_IN || ctrl[smsd_pkg::CTRL_OPEN];

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire logic [35:0] addr     = TXN_IN.addr;
  wire logic [31:0] top_base = ceiling - tsize;
  // Ceiling and size are trusted stable while the segment is on
  wire logic in_top    = (addr < {4'h0, ceiling}) && (addr >= {4'h0, top_base});
  wire logic in_compat = in_range(addr, smsd_pkg::COMPAT_BASE, smsd_pkg::COMPAT_TOP);
  wire logic in_high   = in_range(addr, smsd_pkg::HIGH_BASE, smsd_pkg::HIGH_TOP);
  wire logic in_bios   = in_range(addr, smsd_pkg::BIOS_BASE, smsd_pkg::BIOS_TOP);
  wire logic in_pcigap = (addr >= {4'h0, ceiling}) && (addr < smsd_pkg::FOUR_GB);
  wire logic beyond    = addr >= smsd_pkg::MEM_LIMIT;

  wire logic hit_compat = compat_act && visible && in_compat;
  wire logic hit_high   = high_act && visible && in_high;
  wire logic hit_top    = top_act && visible && in_top;
  wire logic mgmt_hit   = hit_compat || hit_high || hit_top;
  // Closed window touched from outside management mode
  wire logic blocked    = ((compat_act && in_compat) || (high_act && in_high)
                          || (top_act && in_top)) && !visible;

  // BIOS block attributes: read enable and write enable to RAM
  wire logic shd_rd   = shadow[smsd_pkg::SHD_RD];
  wire logic shd_wr   = shadow[smsd_pkg::SHD_WR];
  wire logic bios_ram = TXN_IN.write ? shd_wr : shd_rd;

  // High window folds onto the graphics-area DRAM
  wire logic [35:0] high_dram = smsd_pkg::COMPAT_BASE | {19'h0, addr[smsd_pkg::WIN_OFS_W-1:0]};

  // Target selection, limit check first, then window hits
  smsd_pkg::smsd_target_t next_target;
  always_comb begin
    if (beyond) begin
      next_target = smsd_pkg::SMSD_TGT_NONE;
    end else if (mgmt_hit) begin
      next_target = smsd_pkg::SMSD_TGT_DRAM;
    end else if (in_compat || in_high) begin
      next_target = smsd_pkg::SMSD_TGT_PCI;
    end else if (in_bios) begin
      next_target = bios_ram ? smsd_pkg::SMSD_TGT_DRAM : smsd_pkg::SMSD_TGT_PCI;
    end else if (in_top && top_act) begin
      next_target = smsd_pkg::SMSD_TGT_PCI;
    end else if (in_pcigap) begin
      next_target = smsd_pkg::SMSD_TGT_PCI;
    end else begin
      next_target = smsd_pkg::SMSD_TGT_DRAM;
    end
  end

  // Old upper part of the high segment falls through to normal decode
  wire logic [35:0] next_dram = hit_high ? high_dram : addr;

  // ****************************************************************
  // Route output and status
  // ****************************************************************
  // Registered so DRAM and PCI see a clean one-cycle decision
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      ROUTE_OUT <= '0;
    end else begin
      ROUTE_OUT.valid     <= TXN_IN.valid;
      ROUTE_OUT.target    <= next_target;
      ROUTE_OUT.mgmt_hit  <= TXN_IN.valid && mgmt_hit && !beyond;
      ROUTE_OUT.dram_addr <= next_dram;
    end
  end

  // Count blocked probes; saturates rather than wraps
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      blocked_cnt <= 16'h0000;
    end else if (TXN_IN.valid && blocked && (blocked_cnt != 16'hFFFF)) begin
      blocked_cnt <= blocked_cnt + 16'h0001;
    end
  end

  // Read mux; unmapped offsets read zero
  logic [31:0] next_rdata;
  always_comb begin
    unique case (REG_ADDR_IN)
      smsd_pkg::REG_CTRL:   next_rdata = {28'h0, ctrl};
      smsd_pkg::REG_SHADOW: next_rdata = {30'h0, shadow};
      smsd_pkg::REG_CEIL:   next_rdata = ceiling;
      smsd_pkg::REG_TSIZE:  next_rdata = tsize;
      smsd_pkg::REG_STATUS: next_rdata = {blocked_cnt, 11'h0, visible,
                                          top_act, high_act, compat_act, SYS_MGMT_MODE_IN};
      default:              next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      REG_RDATA_OUT <= 32'h0000_0000;
    end else begin
      REG_RDATA_OUT <= REG_RD_IN ? next_rdata : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);

  sequence bios_read_s;
    TXN_IN.valid && !TXN_IN.write && in_bios;
  endsequence
  sequence bios_write_s;
    TXN_IN.valid && TXN_IN.write && in_bios;
  endsequence
  sequence copy_phase_s;
    !shd_rd && shd_wr;
  endsequence
  sequence locked_phase_s;
    shd_rd && !shd_wr;
  endsequence

  closed_when_off_a: assert property (
    TXN_IN.valid && !global_en && (in_compat || in_high)
    |=> ROUTE_OUT.valid && ROUTE_OUT.target == smsd_pkg::SMSD_TGT_PCI && !ROUTE_OUT.mgmt_hit)
    else $error("window open with global enable clear");

  compat_map_a: assert property (
    TXN_IN.valid && compat_act && visible && in_compat
    |=> ROUTE_OUT.target == smsd_pkg::SMSD_TGT_DRAM && ROUTE_OUT.dram_addr == $past(addr))
    else $error("compatible window not identity mapped to DRAM");

  hidden_ram_a: assert property (
    TXN_IN.valid && !SYS_MGMT_MODE_IN && !ctrl[smsd_pkg::CTRL_OPEN]
    |=> !ROUTE_OUT.mgmt_hit)
    else $error("management RAM exposed outside management mode");

  high_redirect_a: assert property (
    TXN_IN.valid && high_act && visible && in_high
    |=> ROUTE_OUT.target == smsd_pkg::SMSD_TGT_DRAM
        && ROUTE_OUT.dram_addr == (smsd_pkg::COMPAT_BASE | {19'h0, $past(addr[16:0])}))
    else $error("high window not folded onto graphics DRAM");

  old_high_a: assert property (
    TXN_IN.valid && high_act && in_range(addr, smsd_pkg::OLDHI_BASE, smsd_pkg::BIOS_TOP)
    |=> !ROUTE_OUT.mgmt_hit)
    else $error("old upper high segment decoded as management RAM");

  top_identity_a: assert property (
    TXN_IN.valid && hit_top && !beyond
    |=> ROUTE_OUT.mgmt_hit && ROUTE_OUT.dram_addr == $past(addr))
    else $error("top segment address remapped");

  window_excl_a: assert property (
    TXN_IN.valid && ((compat_act && in_high) || (high_act && in_compat))
    |=> ROUTE_OUT.target == smsd_pkg::SMSD_TGT_PCI && !ROUTE_OUT.mgmt_hit)
    else $error("compatible and high windows open together");

  copy_read_a: assert property (
    copy_phase_s and bios_read_s |=> ROUTE_OUT.target == smsd_pkg::SMSD_TGT_PCI)
    else $error("shadow copy read not served by ROM");

  copy_write_a: assert property (
    copy_phase_s and bios_write_s |=> ROUTE_OUT.target == smsd_pkg::SMSD_TGT_DRAM)
    else $error("shadow copy write not placed in DRAM");

  locked_bios_a: assert property (
    locked_phase_s and bios_write_s |=> ROUTE_OUT.target == smsd_pkg::SMSD_TGT_PCI)
    else $error("write to shadowed BIOS reached DRAM");

  locked_read_a: assert property (
    locked_phase_s and bios_read_s |=> ROUTE_OUT.target == smsd_pkg::SMSD_TGT_DRAM)
    else $error("read of shadowed BIOS not served from DRAM");

  beyond_limit_a: assert property (
    TXN_IN.valid && beyond |=> ROUTE_OUT.target == smsd_pkg::SMSD_TGT_NONE)
    else $error("address above 16GB decoded");

  video_route_a: assert property (
    TXN_IN.valid && in_compat && !hit_compat |=> ROUTE_OUT.target == smsd_pkg::SMSD_TGT_PCI)
    else $error("graphics range not sent to video controller");

  rdata_pulse_a: assert property (
    !REG_RD_IN |=> REG_RDATA_OUT == 32'h0000_0000)
    else $error("read data outside its cycle");

endmodule : smsd_decoder

`default_nettype wire

// File: rtl/smsd_pkg.sv
// Behaviour
// - Global, high and top enables pick which management windows may open.
// - Compatible window maps A0000h-BFFFFh to the same DRAM addresses.
// - Management RAM shows only in management mode or when software opens it.
// - High window maps 0FEDA0000h-0FEDBFFFFh onto DRAM A0000h-BFFFFh.
// - High window is only 128 KB; old C0000h-FFFFFh part is not decoded.
// - Top segment spans ceiling minus size to ceiling, identity mapped.
// - Top segment joins either window; compatible and high never both.
// - During shadow copy, reads of the BIOS block return ROM contents.
// - During shadow copy, writes to the BIOS block land in DRAM.
// - After shadowing, reads come from DRAM and writes go to expansion bus.
// - Decoder serves at most 16GB; higher addresses are not decoded.
// - Graphics range outside an open window goes to the video controller.
// - BIOS block resets with reads and writes to RAM disabled.
`default_nettype none

package smsd_pkg;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam int          ADDR_W      = 36;
  localparam int          WIN_OFS_W   = 17;
  localparam logic [35:0] COMPAT_BASE = 36'h0_000A_0000;
  localparam logic [35:0] COMPAT_TOP  = 36'h0_000B_FFFF;
  localparam logic [35:0] HIGH_BASE   = 36'h0_FEDA_0000;
  localparam logic [35:0] HIGH_TOP    = 36'h0_FEDB_FFFF;
  localparam logic [35:0] OLDHI_BASE  = 36'h0_000C_0000;
  localparam logic [35:0] BIOS_BASE   = 36'h0_000F_0000;
  localparam logic [35:0] BIOS_TOP    = 36'h0_000F_FFFF;
  localparam logic [35:0] FOUR_GB     = 36'h1_0000_0000;
  localparam logic [35:0] MEM_LIMIT   = 36'h4_0000_0000;

  // ****************************************************************
  // Registers
  // ****************************************************************
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_SHADOW  = 8'h04;
  localparam logic [7:0]  REG_CEIL    = 8'h08;
  localparam logic [7:0]  REG_TSIZE   = 8'h0C;
  localparam logic [7:0]  REG_STATUS  = 8'h10;
  localparam int          CTRL_GLOBAL = 0;
  localparam int          CTRL_HIGH   = 1;
  localparam int          CTRL_TOP    = 2;
  localparam int          CTRL_OPEN   = 3;
  localparam int          SHD_RD      = 0;
  localparam int          SHD_WR      = 1;
  localparam logic [3:0]  CTRL_RST    = 4'h0;
  localparam logic [1:0]  SHADOW_RST  = 2'h0;
  localparam logic [31:0] CEIL_RST    = 32'h1000_0000;
  localparam logic [31:0] TSIZE_RST   = 32'h0010_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {SMSD_TGT_DRAM, SMSD_TGT_PCI, SMSD_TGT_NONE} smsd_target_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } smsd_txn_t;

  typedef struct packed {
    logic              valid;
    smsd_target_t      target;
    logic              mgmt_hit;
    logic [ADDR_W-1:0] dram_addr;
  } smsd_route_t;

endpackage : smsd_pkg

`default_nettype wire

// File: verif/smsd_target_model.sv
`default_nettype none

// ****************************************************************
// Far-side target model
// ****************************************************************
module smsd_target_model (
  input  wire logic                  clk_in,
  input  wire smsd_pkg::smsd_route_t route_in,
  output var  smsd_pkg::smsd_route_t got_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Accept each routed transaction as DRAM or PCI would; idle cycles leave the
  // last accepted route, so the bench can look any time before the next transaction
  always_ff @(posedge clk_in) begin
    if (route_in.valid) begin
      got_out <= route_in;
    end
  end
endmodule : smsd_target_model

`default_nettype wire

// File: verif/tb_smsd_decoder.sv
`default_nettype none

module tb_smsd_decoder;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic                  clk_sys;
  logic                  reset;
  logic                  mgmt;
  smsd_pkg::smsd_txn_t   txn;
  smsd_pkg::smsd_route_t route;
  smsd_pkg::smsd_route_t got;
  logic [7:0]            reg_addr;
  logic [31:0]           reg_wdata;
  logic [31:0]           reg_rdata;
  logic                  reg_wr;
  logic                  reg_rd;
  int                    n_fail;
  int                    samples_checked;
  int                    cycles;

  smsd_decoder smsd_decoder_i (.CLK_SYS_IN(clk_sys), .RESET_IN(reset), .SYS_MGMT_MODE_IN(mgmt),
    .TXN_IN(txn), .ROUTE_OUT(route), .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata),
    .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(reg_rdata));
  smsd_target_model smsd_target_model_i (.clk_in(clk_sys), .route_in(route), .got_out(got));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic mode(input logic m);
    @(posedge clk_sys);
    mgmt <= m;
  endtask : mode

  // DRAM address is only meaningful when the access lands in DRAM
  task automatic probe(input logic w, input logic [35:0] a, input smsd_pkg::smsd_target_t tgt,
                       input logic hit, input logic [35:0] da);
    @(posedge clk_sys);
    txn <= '{valid: 1'b1, write: w, addr: a};
    @(posedge clk_sys);
    txn.valid <= 1'b0;
    #1;
    chk("valid", 36'(route.valid), 36'h1);
    @(posedge clk_sys);
    #1;
    // Route stands one cycle only, then drops back to idle
    chk("idle", 36'(route.valid), 36'h0);
    chk("target", 36'(got.target), 36'(tgt));
    chk("mgmt_hit", 36'(got.mgmt_hit), 36'(hit));
    if (tgt == smsd_pkg::SMSD_TGT_DRAM) begin
      chk("dram_addr", got.dram_addr, da);
    end
  endtask : probe

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [31:0] d;
    rd(smsd_pkg::REG_CTRL, d);
    chk("ctrl", 36'(d), 36'h0);
    rd(smsd_pkg::REG_SHADOW, d);
    chk("shadow", 36'(d), 36'h0);
    rd(8'h14, d);
    chk("unmapped", 36'(d), 36'h0);
    probe(1'b0, smsd_pkg::BIOS_BASE, smsd_pkg::SMSD_TGT_PCI, 1'b0, 36'h0);
    probe(1'b1, smsd_pkg::BIOS_TOP, smsd_pkg::SMSD_TGT_PCI, 1'b0, 36'h0);
    $display("test reset done");
  endtask : t_reset

  // Every enable combination of the window table, top segment placed first
  task automatic t_windows();
    logic [3:0]  codes [5] = '{4'hE, 4'h9, 4'hD, 4'hB, 4'hF};
    logic        c;
    logic        h;
    logic        t;
    logic [31:0] d;
    wr(smsd_pkg::REG_CEIL, 32'h2000_0000);
    wr(smsd_pkg::REG_TSIZE, 32'h0002_0000);
    rd(smsd_pkg::REG_CEIL, d);
    chk("ceiling", 36'(d), 36'h2000_0000);
    mode(1'b1);
    foreach (codes[i]) begin
      c = codes[i][0] & ~codes[i][1];
      h = codes[i][0] & codes[i][1];
      t = codes[i][0] & codes[i][2];
      wr(smsd_pkg::REG_CTRL, {28'h0, codes[i]});
      probe(1'b0, 36'h0_000A_0123, c ? smsd_pkg::SMSD_TGT_DRAM : smsd_pkg::SMSD_TGT_PCI, c,
            36'h0_000A_0123);
      probe(1'b1, 36'h0_FEDB_2345, h ? smsd_pkg::SMSD_TGT_DRAM : smsd_pkg::SMSD_TGT_PCI, h,
            36'h0_000B_2345);
      // A segment that is not enabled is plain main memory below the ceiling
      probe(1'b1, 36'h0_1FFE_0000, smsd_pkg::SMSD_TGT_DRAM, t,
            36'h0_1FFE_0000);
      probe(1'b0, 36'h0_1FFD_FFFF, smsd_pkg::SMSD_TGT_DRAM, 1'b0, 36'h0_1FFD_FFFF);
      probe(1'b0, smsd_pkg::OLDHI_BASE, smsd_pkg::SMSD_TGT_DRAM, 1'b0,
            smsd_pkg::OLDHI_BASE);
    end
    $display("test windows done");
  endtask : t_windows

  task automatic t_visible();
    logic [31:0] d;
    wr(smsd_pkg::REG_CTRL, 32'h0000_0001);
    mode(1'b0);
    probe(1'b0, 36'h0_000B_FFFF, smsd_pkg::SMSD_TGT_PCI, 1'b0, 36'h0);
    // One blocked probe so far, compatible window on, hidden
    rd(smsd_pkg::REG_STATUS, d);
    chk("status", 36'(d), 36'h0_0001_0002);
    mode(1'b1);
    probe(1'b0, 36'h0_000B_FFFF, smsd_pkg::SMSD_TGT_DRAM, 1'b1, 36'h0_000B_FFFF);
    mode(1'b0);
    wr(smsd_pkg::REG_CTRL, 32'h0000_0009);
    probe(1'b1, 36'h0_000A_0000, smsd_pkg::SMSD_TGT_DRAM, 1'b1, 36'h0_000A_0000);
    $display("test visibility done");
  endtask : t_visible

  // Copy phase is read-to-ROM with write-to-RAM; after it reads come from RAM
  task automatic t_shadow();
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      wr(smsd_pkg::REG_SHADOW, {30'h0, s});
      probe(1'b0, 36'h0_000F_55AA, s[0] ? smsd_pkg::SMSD_TGT_DRAM : smsd_pkg::SMSD_TGT_PCI,
            1'b0, 36'h0_000F_55AA);
      probe(1'b1, 36'h0_000F_55AA, s[1] ? smsd_pkg::SMSD_TGT_DRAM : smsd_pkg::SMSD_TGT_PCI,
            1'b0, 36'h0_000F_55AA);
    end
    $display("test shadow done");
  endtask : t_shadow

  task automatic t_limit();
    probe(1'b0, smsd_pkg::MEM_LIMIT, smsd_pkg::SMSD_TGT_NONE, 1'b0, 36'h0);
    probe(1'b1, 36'h3_FFFF_FFF0, smsd_pkg::SMSD_TGT_DRAM, 1'b0, 36'h3_FFFF_FFF0);
    $display("test limit done");
  endtask : t_limit

  // ****************************************************************
  // Clock, reset, sequence and hang guard
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Ceiling sits far above the roughly 170 cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    reset = 1'b1;
    mgmt = 1'b0;
    txn = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_windows();
    t_visible();
    t_shadow();
    t_limit();
    test_done();
  end
endmodule : tb_smsd_decoder

`default_nettype wire
